// ===== hw/bprc_consts.vh
`ifndef BPRC_CONSTS_VH
`define BPRC_CONSTS_VH

// Clock rate and derived cycles per millisecond.
`define BPRC_CLK_HZ 50000000
`define BPRC_CYC_PER_MS (`BPRC_CLK_HZ / 1000)

// Documented times in milliseconds.
`define BPRC_DEBOUNCE_MS 10
`define BPRC_SOFT_PULSE_MS 10
`define BPRC_SHORT_DELAY_MS 200
`define BPRC_SHORT_PRESS_MS 400
`define BPRC_MID_PRESS_MS 3000
`define BPRC_LONG_PRESS_MS 12000
`define BPRC_LONG_DELAY_MS 15000

// Register byte offsets.
`define BPRC_OFS_CONFIG 8'h00
`define BPRC_OFS_CMD 8'h04
`define BPRC_OFS_STATUS 8'h08

// Reset values and field layout.
`define BPRC_CONFIG_RESET 4'h0
`define BPRC_CMD_OFF 2'h1
`define BPRC_CMD_SEAL 2'h2
`define BPRC_ST_POWER_LSB 0
`define BPRC_ST_HARD_PEND 3
`define BPRC_ST_SOFT_PEND 4
`define BPRC_ST_KEY 5
`define BPRC_ST_CHARGER 6
`define BPRC_ST_RESET_LOW 7

// Configuration codes.
`define BPRC_MODE_LEVEL_HI 4'h0
`define BPRC_MODE_LEVEL_LO 4'h1
`define BPRC_MODE_EDGE_RISE 4'h2
`define BPRC_MODE_EDGE_FALL 4'h3
`define BPRC_MODE_INS_HI 4'h4
`define BPRC_MODE_INS_LO 4'h5
`define BPRC_MODE_KEY 4'h6
`define BPRC_MODE_LONG_ONE 4'h7
`define BPRC_MODE_LONG_TWO 4'h8
`define BPRC_MODE_CUST_HI 4'h9
`define BPRC_MODE_CUST_LO 4'ha
`define BPRC_MODE_KEY_SEAL 4'hb
`define BPRC_MODE_CUST_SEAL 4'hc

`endif

// ===== hw/bprc_debounce.v
`timescale 1ns/10ps
`default_nettype none

module bprc_debounce #(
    parameter [31:0] CYCLES = 32'd500000,
    parameter INIT = 1'b0
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Level in and filtered level out
    input wire raw,
    output reg stable
);

    reg [31:0] cnt;

    // A new level is accepted only after it held for the whole window.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stable <= INIT;
            cnt <= 32'h0;
        end
        else if (raw == stable)
        begin
            cnt <= 32'h0;
        end
        else if (cnt >= CYCLES - 32'd1)
        begin
            stable <= raw;
            cnt <= 32'h0;
        end
        else
        begin
            cnt <= cnt + 32'd1;
        end
    end

endmodule
`default_nettype wire

// ===== hw/bprc_top.v
// Overview of operation
// - Code 0000: A high on/off, B low soft.
// - Code 0001: A low on/off, same B.
// - Code 0010: rising edges reset after 200ms.
// - Code 0011: falling edges reset after 200ms.
// - Always-on and long-press modes: off by command only.
// - Code 0100: high at insertion, reset 200ms later.
// - Code 0101: low at insertion, reset 200ms later.
// - Code 0110: A is key, B mirrors it.
// - Short-press modes: 400ms on, 12s off.
// - Code 0111: 3s on, 12s soft reset.
// - Code 1000: A 3s on, B 12s soft.
// - Custom insertion modes: power on by insertion only.
// - Code 1001: high at insertion, 15s, cancellable.
// - Code 1010: low at insertion, 15s, cancellable.
// - Code 1011: key mode plus off and seal.
// - Code 1100: custom high mode plus off and seal.
// - Soft reset drives reset low for 10ms.
// - Hard reset starts the full power-on sequence.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "bprc_consts.vh"

module bprc_top #(
    parameter [31:0] DEBOUNCE_CYC = `BPRC_DEBOUNCE_MS * `BPRC_CYC_PER_MS,
    parameter [31:0] SOFT_PULSE_CYC = `BPRC_SOFT_PULSE_MS * `BPRC_CYC_PER_MS,
    parameter [31:0] SHORT_DELAY_CYC = `BPRC_SHORT_DELAY_MS * `BPRC_CYC_PER_MS,
    parameter [31:0] SHORT_PRESS_CYC = `BPRC_SHORT_PRESS_MS * `BPRC_CYC_PER_MS,
    parameter [31:0] MID_PRESS_CYC = `BPRC_MID_PRESS_MS * `BPRC_CYC_PER_MS,
    parameter [31:0] LONG_PRESS_CYC = `BPRC_LONG_PRESS_MS * `BPRC_CYC_PER_MS,
    parameter [31:0] LONG_DELAY_CYC = `BPRC_LONG_DELAY_MS * `BPRC_CYC_PER_MS
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // Control pins and charger detect
    input wire control_input_a,
    input wire control_input_b_in,
    output wire control_input_b_out,
    output wire control_input_b_oe,
    input wire charger_supply_input,
    // Power outputs
    output reg power_on,
    output reg seal_mode,
    output reg reset_out_n,
    output reg hard_reset_start
);

    localparam [2:0] ST_OFF = 3'b001;
    localparam [2:0] ST_ON = 3'b010;
    localparam [2:0] ST_SEAL = 3'b100;

    reg [3:0] power_reset_config_code;
    reg [2:0] state;
    reg [2:0] next_state;
    reg chg_d;
    reg a_d;
    reg b_d;
    reg [31:0] hold_a;
    reg [31:0] hold_b;
    reg hard_pend;
    reg soft_pend;
    reg [31:0] hard_cnt;
    reg [31:0] soft_cnt;
    reg [31:0] rst_cnt;
    reg wr_pend;
    reg [7:0] wr_addr;
    reg [1:0] cmd_req;
    wire deb_a;
    wire deb_b;

    bprc_debounce #(.CYCLES(DEBOUNCE_CYC), .INIT(1'b1)) u_deb_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw(control_input_a),
        .stable(deb_a)
    );

    bprc_debounce #(.CYCLES(DEBOUNCE_CYC), .INIT(1'b1)) u_deb_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw(control_input_b_in),
        .stable(deb_b)
    );

    wire [3:0] mode = power_reset_config_code;
    wire m_level = (mode == `BPRC_MODE_LEVEL_HI) || (mode == `BPRC_MODE_LEVEL_LO);
    wire m_edge = (mode == `BPRC_MODE_EDGE_RISE) || (mode == `BPRC_MODE_EDGE_FALL);
    wire m_ins = (mode == `BPRC_MODE_INS_HI) || (mode == `BPRC_MODE_INS_LO);
    wire m_key = (mode == `BPRC_MODE_KEY) || (mode == `BPRC_MODE_KEY_SEAL);
    wire m_long1 = (mode == `BPRC_MODE_LONG_ONE);
    wire m_long2 = (mode == `BPRC_MODE_LONG_TWO);
    wire m_cust = (mode == `BPRC_MODE_CUST_HI) || (mode == `BPRC_MODE_CUST_LO) || (mode == `BPRC_MODE_CUST_SEAL);
    wire m_seal_ok = (mode == `BPRC_MODE_KEY_SEAL) || (mode == `BPRC_MODE_CUST_SEAL);
    wire m_keyed = m_key || m_long1 || m_long2;
    // Codes that read the inputs high-active; pin B stays low-active in the level codes.
    wire hi_act = (mode == `BPRC_MODE_LEVEL_HI) || (mode == `BPRC_MODE_EDGE_RISE) ||
        (mode == `BPRC_MODE_INS_HI) || (mode == `BPRC_MODE_CUST_HI) || (mode == `BPRC_MODE_CUST_SEAL);
    wire valid_mode = (mode <= `BPRC_MODE_CUST_SEAL);

    wire a_act = valid_mode && (deb_a == hi_act);
    wire b_act = valid_mode && (deb_b == (hi_act && !m_level));
    wire a_act_d = (a_d == hi_act);
    wire b_act_d = (b_d == (hi_act && !m_level));
    wire chg_ins = charger_supply_input && !chg_d;
    wire pin_b_is_key_out = m_key || m_long1;

    assign control_input_b_out = 1'b0;
    assign control_input_b_oe = pin_b_is_key_out && !control_input_a;

    // Events from the control inputs, each qualified by its mode.
    // edge resets
    wire edge_hard = m_edge && a_act && !a_act_d;
    wire edge_soft = m_edge && b_act && !b_act_d;
    wire ins_hard = m_ins && chg_ins && a_act;
    wire ins_soft = m_ins && chg_ins && b_act;
    wire cust_hard = m_cust && chg_ins && a_act;
    wire cust_soft = m_cust && chg_ins && b_act;
    wire lvl_soft = m_level && b_act && !b_act_d;
    wire key_a = m_keyed && a_act;
    wire key_short = m_key && key_a && (hold_a == SHORT_PRESS_CYC - 32'd1);
    wire key_mid = (m_long1 || m_long2) && key_a && (hold_a == MID_PRESS_CYC - 32'd1);
    wire key_long = m_keyed && key_a && (hold_a == LONG_PRESS_CYC - 32'd1);
    wire b_long = m_long2 && b_act && (hold_b == LONG_PRESS_CYC - 32'd1);
    wire hard_fire = hard_pend && (hard_cnt == 32'd1);
    wire soft_fire = soft_pend && (soft_cnt == 32'd1);
    wire soft_now = (state == ST_ON) && (lvl_soft || soft_fire || (m_long1 && key_long) || b_long);

    // Power state. Commands win over pin events in the same cycle.
    always @*
    begin
        next_state = state;
        case (state)
            ST_OFF, ST_SEAL:
            begin
                if (m_cust && chg_ins)
                    next_state = ST_ON;
                else if (m_level && a_act)
                    next_state = ST_ON;
                else if (!m_level && !m_cust && valid_mode && (chg_ins || key_short || key_mid))
                    next_state = ST_ON;
            end
            ST_ON:
            begin
                if (cmd_req == `BPRC_CMD_SEAL && m_seal_ok)
                    next_state = ST_SEAL;
                else if (cmd_req != 2'h0)
                    next_state = ST_OFF;
                else if (m_level && !a_act && valid_mode)
                    next_state = ST_OFF;
                else if (m_key && key_long)
                    next_state = ST_OFF;
            end
            default:
            begin
                next_state = ST_OFF;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= ST_OFF;
            chg_d <= 1'b0;
            a_d <= 1'b1;
            b_d <= 1'b1;
            hold_a <= 32'h0;
            hold_b <= 32'h0;
            power_on <= 1'b0;
            seal_mode <= 1'b0;
        end
        else
        begin
            state <= next_state;
            chg_d <= charger_supply_input;
            a_d <= deb_a;
            b_d <= deb_b;
            power_on <= (next_state == ST_ON);
            seal_mode <= (next_state == ST_SEAL);
            // Hold counters saturate so each threshold fires once per press.
            if (!key_a)
                hold_a <= 32'h0;
            else if (hold_a != 32'hffffffff)
                hold_a <= hold_a + 32'd1;
            if (!(m_long2 && b_act))
                hold_b <= 32'h0;
            else if (hold_b != 32'hffffffff)
                hold_b <= hold_b + 32'd1;
        end
    end

    // Delayed reset timers; a pending reset is dropped when power goes away.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hard_pend <= 1'b0;
            soft_pend <= 1'b0;
            hard_cnt <= 32'h0;
            soft_cnt <= 32'h0;
        end
        else if (state != ST_ON || !valid_mode)
        begin
            hard_pend <= 1'b0;
            soft_pend <= 1'b0;
        end
        else
        begin
            if (edge_hard || ins_hard)
            begin
                hard_pend <= 1'b1;
                hard_cnt <= SHORT_DELAY_CYC;
            end
            else if (hard_fire)
                hard_pend <= 1'b0;
            else if (m_cust && hard_pend && !a_act)
                hard_pend <= 1'b0;
            else if (hard_pend)
                hard_cnt <= hard_cnt - 32'd1;
            if (edge_soft || ins_soft)
            begin
                soft_pend <= 1'b1;
                soft_cnt <= SHORT_DELAY_CYC;
            end
            else if (soft_fire)
                soft_pend <= 1'b0;
            else if (m_cust && soft_pend && !b_act)
                soft_pend <= 1'b0;
            else if (soft_pend)
                soft_cnt <= soft_cnt - 32'd1;
            // Insertion in the custom modes arms the long delay instead.
            if (cust_hard)
            begin
                hard_pend <= 1'b1;
                hard_cnt <= LONG_DELAY_CYC;
            end
            if (cust_soft)
            begin
                soft_pend <= 1'b1;
                soft_cnt <= LONG_DELAY_CYC;
            end
        end
    end

    // Reset outputs.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rst_cnt <= 32'h0;
            reset_out_n <= 1'b1;
            hard_reset_start <= 1'b0;
        end
        else
        begin
            hard_reset_start <= (state == ST_ON) && hard_fire;
            if (soft_now)
            begin
                rst_cnt <= SOFT_PULSE_CYC;
                reset_out_n <= 1'b0;
            end
            else if (rst_cnt > 32'd1)
                rst_cnt <= rst_cnt - 32'd1;
            else
            begin
                rst_cnt <= 32'h0;
                reset_out_n <= 1'b1;
            end
        end
    end

    // Bus slave: zero wait states, read data registered in the address phase.
    wire bus_go = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    wire [31:0] status_word = {24'h0, !reset_out_n, charger_supply_input, !deb_a, soft_pend, hard_pend, state};

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0;
            wr_pend <= 1'b0;
            wr_addr <= 8'h0;
            power_reset_config_code <= `BPRC_CONFIG_RESET;
            cmd_req <= 2'h0;
        end
        else
        begin
            wr_pend <= bus_go && hwrite;
            if (bus_go)
                wr_addr <= haddr;
            cmd_req <= 2'h0;
            if (bus_go && !hwrite)
            begin
                case (haddr)
                    `BPRC_OFS_CONFIG: hrdata <= {28'h0, power_reset_config_code};
                    `BPRC_OFS_STATUS: hrdata <= status_word;
                    default: hrdata <= 32'h0;
                endcase
            end
            if (wr_pend && wr_addr == `BPRC_OFS_CONFIG)
                power_reset_config_code <= hwdata[3:0];
            if (wr_pend && wr_addr == `BPRC_OFS_CMD)
                cmd_req <= hwdata[1:0];
        end
    end

endmodule
`default_nettype wire

// ===== tb/bprc_top_properties.sv
`timescale 1ns/10ps
`default_nettype none

module bprc_props (
    // Clock, reset and bus
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    // Pins and power outputs
    input wire control_input_a,
    input wire control_input_b_out,
    input wire control_input_b_oe,
    input wire power_on,
    input wire seal_mode,
    input wire reset_out_n,
    input wire hard_reset_start
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_read;
        hsel && htrans[1] && hready && !hwrite;
    endsequence

    sequence s_soft;
        $fell(reset_out_n) ##0 !reset_out_n [*7];
    endsequence

    a_soft_pulse_len: assert property (s_soft |-> ##[1:3] reset_out_n)
        else $error("soft reset pulse has the wrong length");
    a_soft_when_on: assert property ($fell(reset_out_n) |-> power_on)
        else $error("soft reset while not powered");
    a_hard_one_cycle: assert property (hard_reset_start |=> !hard_reset_start)
        else $error("hard reset start longer than one cycle");
    a_hard_when_on: assert property (hard_reset_start |-> power_on)
        else $error("hard reset while not powered");
    a_mirror_key: assert property (control_input_b_oe |-> !control_input_a && !control_input_b_out)
        else $error("pin B mirror does not follow the key");
    a_on_seal_excl: assert property (!(power_on && seal_mode))
        else $error("on and seal at once");
    a_read_zero: assert property (s_read ##0 haddr != 8'h00 && haddr != 8'h08 |=> hrdata == 32'h0)
        else $error("command or unmapped read not zero");
    a_status_state: assert property (s_read ##0 haddr == 8'h08 |=>
        hrdata[2:0] == {$past(seal_mode), $past(power_on), !$past(power_on) && !$past(seal_mode)}
        && hrdata[7] == !$past(reset_out_n))
        else $error("status read disagrees with outputs");
endmodule

bind bprc_top bprc_props i_props (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hrdata(hrdata),
    .control_input_a(control_input_a),
    .control_input_b_out(control_input_b_out),
    .control_input_b_oe(control_input_b_oe),
    .power_on(power_on),
    .seal_mode(seal_mode),
    .reset_out_n(reset_out_n),
    .hard_reset_start(hard_reset_start)
);

`default_nettype wire

// ===== tb/bprc_button_model.sv
`timescale 1ns/10ps
`default_nettype none

module bprc_button_model (
    // Clock
    input wire logic hclk,
    // Pin B as driven by the block
    input wire logic b_out,
    input wire logic b_oe,
    // Lines into the block
    output logic pin_a,
    output wire logic pin_b,
    output logic charger
);
    logic b_drv;

    // Pin B has a pull-up, so a released line reads high.
    assign pin_b = (b_oe ? b_out : 1'b1) & b_drv;

    initial
    begin
        pin_a = 1'b0;
        b_drv = 1'b1;
        charger = 1'b0;
    end

    // Levels change just after an edge and then hold.
    task automatic drive(input logic [1:0] sel, input logic v);
        @(posedge hclk);
        case (sel)
            2'h0: pin_a <= v;
            2'h1: b_drv <= v;
            default: charger <= v;
        endcase
    endtask
endmodule

`default_nettype wire

// ===== tb/bprc_top_test.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end

module bprc_top_test;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] r;
    wire [31:0] hrdata;
    wire hreadyout, pin_a, pin_b, b_out, b_oe, chg, power_on, reset_out_n, hard, hresp, seal;
    int fails = 0;
    int n_compared = 0;
    int n;

    always #10 hclk = ~hclk;

    bprc_top #(.DEBOUNCE_CYC(32'd4), .SOFT_PULSE_CYC(32'd8), .SHORT_DELAY_CYC(32'd20),
        .SHORT_PRESS_CYC(32'd30), .MID_PRESS_CYC(32'd50), .LONG_PRESS_CYC(32'd100),
        .LONG_DELAY_CYC(32'd150)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .control_input_a(pin_a), .control_input_b_in(pin_b), .control_input_b_out(b_out),
        .control_input_b_oe(b_oe), .charger_supply_input(chg), .power_on(power_on),
        .seal_mode(seal), .reset_out_n(reset_out_n), .hard_reset_start(hard));

    bprc_button_model i_btn (.hclk(hclk), .b_out(b_out), .b_oe(b_oe), .pin_a(pin_a),
        .pin_b(pin_b), .charger(chg));

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic probe(input int s);
        return s == 0 ? power_on : (s == 1 ? reset_out_n : hard);
    endfunction

    // A limit that runs out is a mismatch and ends the run.
    task automatic wait_on(input int s, input logic v, input int lim, output int k);
        k = 0;
        while (probe(s) !== v)
        begin
            @(posedge hclk);
            #1;
            k++;
            if (k > lim)
            begin
                fails++;
                finish_test();
            end
        end
    endtask

    task automatic hold(input int s, input logic v, input int c);
        repeat (c)
        begin
            @(posedge hclk);
            #1;
            `CHK(probe(s), v)
        end
    endtask

    task automatic wait_rdy();
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
            if (k > 50)
            begin
                fails++;
                finish_test();
            end
        end while (hreadyout !== 1'b1);
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask

    task automatic t_regs();
        for (int c = 0; c < 16; c++)
        begin
            bus(8'h00, 1'b1, 32'(c));
            bus(8'h00, 1'b0, 32'h0);
            `CHK(r[3:0], 4'(c))
        end
        bus(8'h04, 1'b0, 32'h0);
        `CHK(r, 32'h0)
        `CHK(hresp, 1'b0)
        bus(8'h0c, 1'b0, 32'h0);
        `CHK(r, 32'h0)
        bus(8'h00, 1'b1, 32'h0);
    endtask

    task automatic t_level();
        repeat (12) @(posedge hclk);
        hold(0, 1'b0, 3);
        i_btn.drive(0, 1'b1);
        wait_on(0, 1'b1, 20, n);
        `CHK(n >= 4, 1'b1)
        i_btn.drive(1, 1'b0);
        wait_on(1, 1'b0, 20, n);
        wait_on(1, 1'b1, 20, n);
        `CHK(n >= 7 && n <= 9, 1'b1)
        i_btn.drive(1, 1'b1);
        bus(8'h00, 1'b1, 32'h1);
        wait_on(0, 1'b0, 20, n);
        i_btn.drive(0, 1'b0);
        wait_on(0, 1'b1, 20, n);
        `CHK(n >= 4, 1'b1)
    endtask

    task automatic t_edge();
        bus(8'h00, 1'b1, 32'h2);
        i_btn.drive(2, 1'b1);
        i_btn.drive(0, 1'b1);
        wait_on(2, 1'b1, 40, n);
        `CHK(n >= 20, 1'b1)
        i_btn.drive(0, 1'b0);
        hold(0, 1'b1, 30);
        bus(8'h00, 1'b1, 32'h3);
        i_btn.drive(0, 1'b1);
        hold(2, 1'b0, 30);
        i_btn.drive(0, 1'b0);
        wait_on(2, 1'b1, 40, n);
        `CHK(n >= 20, 1'b1)
        i_btn.drive(1, 1'b0);
        wait_on(1, 1'b0, 40, n);
        `CHK(n >= 20, 1'b1)
        i_btn.drive(1, 1'b1);
        bus(8'h04, 1'b1, 32'h1);
        wait_on(0, 1'b0, 5, n);
        `CHK(n <= 3, 1'b1)
        i_btn.drive(2, 1'b0);
    endtask

    task automatic t_key();
        i_btn.drive(0, 1'b1);
        repeat (8) @(posedge hclk);
        bus(8'h00, 1'b1, 32'h6);
        i_btn.drive(0, 1'b0);
        repeat (2) @(posedge hclk);
        #1;
        `CHK(pin_b, 1'b0)
        wait_on(0, 1'b1, 60, n);
        `CHK(n >= 28, 1'b1)
        wait_on(0, 1'b0, 120, n);
        `CHK(n >= 60, 1'b1)
        i_btn.drive(0, 1'b1);
        repeat (3) @(posedge hclk);
        #1;
        `CHK(pin_b, 1'b1)
        i_btn.drive(2, 1'b1);
        wait_on(0, 1'b1, 10, n);
        bus(8'h04, 1'b1, 32'h1);
        wait_on(0, 1'b0, 5, n);
        i_btn.drive(2, 1'b0);
    endtask

    task automatic t_reserved_custom();
        bus(8'h00, 1'b1, 32'hd);
        i_btn.drive(2, 1'b1);
        i_btn.drive(0, 1'b0);
        hold(0, 1'b0, 60);
        i_btn.drive(0, 1'b1);
        i_btn.drive(2, 1'b0);
        bus(8'h00, 1'b1, 32'h9);
        hold(0, 1'b0, 20);
        i_btn.drive(2, 1'b1);
        wait_on(0, 1'b1, 10, n);
        i_btn.drive(2, 1'b0);
        i_btn.drive(2, 1'b1);
        repeat (30) @(posedge hclk);
        bus(8'h08, 1'b0, 32'h0);
        `CHK(r[3], 1'b1)
        i_btn.drive(0, 1'b0);
        hold(2, 1'b0, 200);
        bus(8'h08, 1'b0, 32'h0);
        `CHK(r[3], 1'b0)
        i_btn.drive(2, 1'b0);
        i_btn.drive(0, 1'b1);
        repeat (8) @(posedge hclk);
        i_btn.drive(2, 1'b1);
        wait_on(2, 1'b1, 200, n);
        `CHK(n >= 140, 1'b1)
    endtask

    task automatic t_seal();
        bus(8'h04, 1'b1, 32'h1);
        i_btn.drive(2, 1'b0);
        bus(8'h00, 1'b1, 32'hb);
        i_btn.drive(2, 1'b1);
        wait_on(0, 1'b1, 10, n);
        bus(8'h04, 1'b1, 32'h2);
        wait_on(0, 1'b0, 5, n);
        `CHK(seal, 1'b1)
        bus(8'h08, 1'b0, 32'h0);
        `CHK(r[7:0], 8'h44)
        i_btn.drive(2, 1'b0);
        i_btn.drive(0, 1'b0);
        wait_on(0, 1'b1, 60, n);
        `CHK(n >= 28, 1'b1)
        `CHK(seal, 1'b0)
        i_btn.drive(0, 1'b1);
        bus(8'h04, 1'b1, 32'h1);
        wait_on(0, 1'b0, 5, n);
    endtask

    task automatic t_ins();
        bus(8'h00, 1'b1, 32'h4);
        i_btn.drive(2, 1'b1);
        wait_on(0, 1'b1, 10, n);
        i_btn.drive(2, 1'b0);
        i_btn.drive(2, 1'b1);
        wait_on(2, 1'b1, 40, n);
        `CHK(n >= 20, 1'b1)
        `CHK(reset_out_n, 1'b0)
        i_btn.drive(2, 1'b0);
        bus(8'h00, 1'b1, 32'h5);
        i_btn.drive(1, 1'b0);
        repeat (8) @(posedge hclk);
        i_btn.drive(2, 1'b1);
        wait_on(1, 1'b0, 40, n);
        `CHK(n >= 20, 1'b1)
        i_btn.drive(1, 1'b1);
        i_btn.drive(2, 1'b0);
        bus(8'h04, 1'b1, 32'h1);
        wait_on(0, 1'b0, 5, n);
    endtask

    task automatic t_long();
        bus(8'h00, 1'b1, 32'h7);
        i_btn.drive(0, 1'b0);
        wait_on(0, 1'b1, 70, n);
        `CHK(n >= 50, 1'b1)
        `CHK(pin_b, 1'b0)
        wait_on(1, 1'b0, 70, n);
        `CHK(n >= 45, 1'b1)
        i_btn.drive(0, 1'b1);
        hold(0, 1'b1, 5);
    endtask

    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_level();
        t_edge();
        t_key();
        t_reserved_custom();
        t_seal();
        t_ins();
        t_long();
        finish_test();
    end
endmodule

`default_nettype wire
